/* File: core/cwd_pkg.sv */
package cwd_pkg;

  // register word indexes on the plain register port
  localparam logic [3:0] REG_CONFIG  = 4'h0;
  localparam logic [3:0] REG_CALIB   = 4'h1;
  localparam logic [3:0] REG_CONTROL = 4'h2;
  localparam logic [3:0] REG_STATUS  = 4'h3;
  localparam logic [3:0] REG_ERASE   = 4'h4;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CFG_W  = 12;

  // configuration word field positions
  localparam int CFG_CLK_MON_BIT   = 11;
  localparam int CFG_SWITCHOVER_BIT = 10;
  localparam int CFG_BOR_HI        = 9;
  localparam int CFG_BOR_LO        = 8;
  localparam int CFG_DATA_PROT_BIT = 7;
  localparam int CFG_PROG_PROT_BIT = 6;
  localparam int CFG_RST_PIN_BIT   = 5;
  localparam int CFG_POWERUP_TIMER_DIS_BIT  = 4;
  localparam int CFG_WDT_BIT       = 3;
  localparam int CFG_OSC_HI        = 2;
  localparam int CFG_OSC_LO        = 0;

  // unimplemented top bits read as ones
  localparam logic [3:0]        CFG_TOP_ONES  = 4'hF;
  localparam logic [CFG_W-1:0]  CFG_ERASED    = 12'hFFF;
  localparam logic [DATA_W-1:0] CALIB_RESET   = 16'h0000;

  // control register bits
  localparam int CTL_SW_BOR_BIT = 0;
  localparam int CTL_SW_WDT_BIT = 1;
  // erase register command bit
  localparam int ERASE_BULK_BIT = 0;

  // brown-out mode codes
  localparam logic [1:0] BOR_ALWAYS   = 2'h3;
  localparam logic [1:0] BOR_AWAKE    = 2'h2;
  localparam logic [1:0] BOR_SOFTWARE = 2'h1;
  localparam logic [1:0] BOR_OFF      = 2'h0;

  // oscillator mode codes
  localparam logic [2:0] OSC_RC_CLKOUT   = 3'h7;
  localparam logic [2:0] OSC_RC_IO       = 3'h6;
  localparam logic [2:0] OSC_INT_CLKOUT  = 3'h5;
  localparam logic [2:0] OSC_INT_IO      = 3'h4;
  localparam logic [2:0] OSC_EXT_CLK     = 3'h3;
  localparam logic [2:0] OSC_HS_CRYSTAL  = 3'h2;
  localparam logic [2:0] OSC_XT_CRYSTAL  = 3'h1;
  localparam logic [2:0] OSC_LP_CRYSTAL  = 3'h0;

  // power-up timer
  localparam int POWERUP_TIMER_TIME_MS = 64;
  localparam int CLK_KHZ      = 125000;
  localparam int POWERUP_TIMER_CYCLES  = POWERUP_TIMER_TIME_MS * CLK_KHZ;
  localparam int POWERUP_TIMER_W       = 24;

  typedef enum logic [2:0] {
    CWD_SRC_RC,
    CWD_SRC_INTERNAL,
    CWD_SRC_EXT_CLOCK,
    CWD_SRC_HS,
    CWD_SRC_XT,
    CWD_SRC_LP
  } cwd_clk_src_t;

  typedef struct packed {
    cwd_clk_src_t source;
    logic         clkout_drive;
    logic         clkin_is_io;
    logic         osc2_is_io;
  } cwd_osc_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cwd_reg_req_t;

  localparam cwd_osc_t OSC_RESET = '{CWD_SRC_RC, 1'b0, 1'b0, 1'b0};

endpackage : cwd_pkg

/* File: core/cwd_powerup_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module cwd_powerup_timer #(
  parameter int unsigned CYCLES = cwd_pkg::POWERUP_TIMER_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic enable,
  output var  logic busy
);

  localparam logic [cwd_pkg::POWERUP_TIMER_W-1:0] LAST = cwd_pkg::POWERUP_TIMER_W'(CYCLES - 1);

  logic [cwd_pkg::POWERUP_TIMER_W-1:0] count_r;

  // a new start re-arms the count even while running
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_r <= '0;
      busy    <= 1'b0;
    end
    else if (ce)
    begin
      if (start && enable)
      begin
        count_r <= LAST;
        busy    <= 1'b1;
      end
      else if (busy)
      begin
        if (count_r == '0)
          busy <= 1'b0;
        else
          count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : cwd_powerup_timer

`default_nettype wire

/* File: core/cwd_config_decoder.sv */
// Operation
// - configuration bits 15..12 always read back as ones
// - bit 11 enables the fail-safe clock monitor
// - bit 10 enables internal/external clock switchover
// - bits 9..8 pick brown-out mode: always, awake only, software, off
// - in software mode the control register bit gates brown-out reset
// - bit 7 low protects data memory from readout
// - bit 6 low protects program memory from readout
// - bit 5 high makes the pin external reset, else input and reset idle
// - bit 4 low enables the power-up timer
// - bit 3 forces watchdog on, else software bit decides
// - code 111: RC on clock-in, clock out on second pin
// - code 110: RC on clock-in, second pin is general I/O
// - code 101: internal clock, clock out, clock-in pin general I/O
// - code 100: internal clock, both oscillator pins general I/O
// - brown-out enable never turns on the power-up timer by itself
// - lifting data protection erases the whole data memory
// - lifting program protection erases the whole program memory
// - external reset in internal or RC mode stops the internal clock
// - calibration values live in a separate fuse word
// - bulk erase leaves the calibration word untouched
// - awake-only mode ignores software bit, off in sleep, on at wake
// - enabled power-up timer holds reset 64 ms after power-on or an armed brown-out
`timescale 1ns/100ps
`default_nettype none

module cwd_config_decoder #(
  parameter int unsigned POWERUP_TIMER_CYCLES = cwd_pkg::POWERUP_TIMER_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  input  wire cwd_pkg::cwd_reg_req_t        reg_req,
  output var  logic [cwd_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                         prog_mode,
  input  wire logic [cwd_pkg::CFG_W-1:0]    nv_config,
  input  wire logic [cwd_pkg::DATA_W-1:0]   nv_calib,
  input  wire logic                         external_reset_n,
  input  wire logic                         sleep_active,
  input  wire logic                         brownout_event,
  output var  logic                         clock_monitor_enable,
  output var  logic                         clock_switchover_enable,
  output var  logic                         brownout_reset_enable,
  output var  logic                         data_read_protect,
  output var  logic                         program_read_protect,
  output var  logic                         external_reset_req,
  output var  logic                         reset_pin_is_input,
  output var  logic                         watchdog_enable,
  output var  cwd_pkg::cwd_osc_t            osc_cfg,
  output var  logic                         internal_osc_run,
  output var  logic                         hold_reset,
  output var  logic                         data_erase,
  output var  logic                         program_erase,
  output var  logic [cwd_pkg::DATA_W-1:0]   calib_word
);

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_START,
    ST_WAIT,
    ST_RUN
  } cwd_state_t;

  function automatic cwd_pkg::cwd_osc_t osc_decode(input logic [2:0] code);
    cwd_pkg::cwd_osc_t o;
    o = cwd_pkg::OSC_RESET;
    unique case (code)
      cwd_pkg::OSC_RC_CLKOUT:
        o = '{cwd_pkg::CWD_SRC_RC, 1'b1, 1'b0, 1'b0};
      cwd_pkg::OSC_RC_IO:
        o = '{cwd_pkg::CWD_SRC_RC, 1'b0, 1'b0, 1'b1};
      cwd_pkg::OSC_INT_CLKOUT:
        o = '{cwd_pkg::CWD_SRC_INTERNAL, 1'b1, 1'b1, 1'b0};
      cwd_pkg::OSC_INT_IO:
        o = '{cwd_pkg::CWD_SRC_INTERNAL, 1'b0, 1'b1, 1'b1};
      cwd_pkg::OSC_EXT_CLK:
        o = '{cwd_pkg::CWD_SRC_EXT_CLOCK, 1'b0, 1'b0, 1'b1};
      cwd_pkg::OSC_HS_CRYSTAL:
        o = '{cwd_pkg::CWD_SRC_HS, 1'b0, 1'b0, 1'b0};
      cwd_pkg::OSC_XT_CRYSTAL:
        o = '{cwd_pkg::CWD_SRC_XT, 1'b0, 1'b0, 1'b0};
      cwd_pkg::OSC_LP_CRYSTAL:
        o = '{cwd_pkg::CWD_SRC_LP, 1'b0, 1'b0, 1'b0};
    endcase
    return o;
  endfunction : osc_decode

  // internal or rc modes run from an on-chip oscillator or rc network
  function automatic logic osc_is_on_chip(input logic [2:0] code);
    return code[2];
  endfunction : osc_is_on_chip

  cwd_state_t                  state_r;
  logic [cwd_pkg::CFG_W-1:0]   cfg_r;
  logic [cwd_pkg::CFG_W-1:0]   cfg_nxt;
  logic [cwd_pkg::DATA_W-1:0]  calib_nxt;
  logic                        sw_bor_r;
  logic                        sw_wdt_r;
  logic                        bulk_erase;
  logic                        cfg_write;
  logic                        calib_write;
  logic                        powerup_timer_start;
  logic                        powerup_timer_busy;
  logic [1:0]                  bor_mode;
  logic                        bor_active;
  logic                        ext_rst_active;
  logic [cwd_pkg::DATA_W-1:0]  status_word;
  logic [cwd_pkg::DATA_W-1:0]  rdata_nxt;

  assign cfg_write   = ce && reg_req.wr && prog_mode && (reg_req.addr == cwd_pkg::REG_CONFIG);
  assign calib_write = ce && reg_req.wr && prog_mode && (reg_req.addr == cwd_pkg::REG_CALIB);
  assign bulk_erase  = ce && reg_req.wr && prog_mode && (reg_req.addr == cwd_pkg::REG_ERASE)
                       && reg_req.wdata[cwd_pkg::ERASE_BULK_BIT];
  assign bor_mode    = cfg_r[cwd_pkg::CFG_BOR_HI:cwd_pkg::CFG_BOR_LO];

  // bulk erase returns the word to its unprogrammed state
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (bulk_erase)
      cfg_nxt = cwd_pkg::CFG_ERASED;
    else if (cfg_write)
      cfg_nxt = reg_req.wdata[cwd_pkg::CFG_W-1:0];
  end

  always_comb
  begin
    calib_nxt = calib_word;
    if (calib_write)
      calib_nxt = reg_req.wdata;
  end

  // load sequence: capture the stored words, then run the power-up timer
  always_ff @(posedge clk)
  begin
    if (rst)
      state_r <= ST_LOAD;
    else if (ce)
    begin
      unique case (state_r)
        ST_LOAD:  state_r <= ST_START;
        ST_START: state_r <= ST_WAIT;
        ST_WAIT:  state_r <= powerup_timer_busy ? ST_WAIT : ST_RUN;
        ST_RUN:   state_r <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_r <= cwd_pkg::CFG_ERASED;
    else if (ce)
    begin
      if (state_r == ST_LOAD)
        cfg_r <= nv_config;
      else
        cfg_r <= cfg_nxt;
    end
  end

  // calibration fuses are a separate word that bulk erase never touches
  always_ff @(posedge clk)
  begin
    if (rst)
      calib_word <= cwd_pkg::CALIB_RESET;
    else if (ce)
    begin
      if (state_r == ST_LOAD)
        calib_word <= nv_calib;
      else
        calib_word <= calib_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sw_bor_r <= 1'b0;
      sw_wdt_r <= 1'b0;
    end
    else if (ce && reg_req.wr && reg_req.addr == cwd_pkg::REG_CONTROL)
    begin
      sw_bor_r <= reg_req.wdata[cwd_pkg::CTL_SW_BOR_BIT];
      sw_wdt_r <= reg_req.wdata[cwd_pkg::CTL_SW_WDT_BIT];
    end
  end

  // erase pulses whenever a protection bit goes from on to off
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_erase    <= 1'b0;
      program_erase <= 1'b0;
    end
    else if (ce)
    begin
      data_erase    <= bulk_erase || (state_r != ST_LOAD
                       && !cfg_r[cwd_pkg::CFG_DATA_PROT_BIT]
                       && cfg_nxt[cwd_pkg::CFG_DATA_PROT_BIT]);
      program_erase <= bulk_erase || (state_r != ST_LOAD
                       && !cfg_r[cwd_pkg::CFG_PROG_PROT_BIT]
                       && cfg_nxt[cwd_pkg::CFG_PROG_PROT_BIT]);
    end
    else
    begin
      data_erase    <= 1'b0;
      program_erase <= 1'b0;
    end
  end

  always_comb
  begin
    unique case (bor_mode)
      cwd_pkg::BOR_ALWAYS:   bor_active = 1'b1;
      cwd_pkg::BOR_AWAKE:    bor_active = !sleep_active;
      cwd_pkg::BOR_SOFTWARE: bor_active = sw_bor_r;
      cwd_pkg::BOR_OFF:      bor_active = 1'b0;
    endcase
  end

  assign ext_rst_active = cfg_r[cwd_pkg::CFG_RST_PIN_BIT] && !external_reset_n;

  // timer fires on power-on and on a brown-out that is armed
  assign powerup_timer_start = (state_r == ST_START) || (bor_active && brownout_event);

  cwd_powerup_timer #(
    .CYCLES (POWERUP_TIMER_CYCLES)
  ) u_powerup_timer (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .start  (powerup_timer_start),
    .enable (!cfg_r[cwd_pkg::CFG_POWERUP_TIMER_DIS_BIT]),
    .busy   (powerup_timer_busy)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clock_monitor_enable    <= 1'b0;
      clock_switchover_enable <= 1'b0;
      brownout_reset_enable   <= 1'b0;
      data_read_protect       <= 1'b1;
      program_read_protect    <= 1'b1;
      external_reset_req      <= 1'b0;
      reset_pin_is_input      <= 1'b0;
      watchdog_enable         <= 1'b0;
      osc_cfg                 <= cwd_pkg::OSC_RESET;
      internal_osc_run        <= 1'b0;
      hold_reset              <= 1'b1;
    end
    else if (ce)
    begin
      clock_monitor_enable    <= cfg_r[cwd_pkg::CFG_CLK_MON_BIT];
      clock_switchover_enable <= cfg_r[cwd_pkg::CFG_SWITCHOVER_BIT];
      brownout_reset_enable   <= bor_active;
      data_read_protect       <= !cfg_r[cwd_pkg::CFG_DATA_PROT_BIT];
      program_read_protect    <= !cfg_r[cwd_pkg::CFG_PROG_PROT_BIT];
      external_reset_req      <= ext_rst_active;
      reset_pin_is_input      <= !cfg_r[cwd_pkg::CFG_RST_PIN_BIT];
      watchdog_enable         <= cfg_r[cwd_pkg::CFG_WDT_BIT] || sw_wdt_r;
      osc_cfg                 <= osc_decode(cfg_r[cwd_pkg::CFG_OSC_HI:cwd_pkg::CFG_OSC_LO]);
      internal_osc_run        <= !(ext_rst_active
                                   && osc_is_on_chip(cfg_r[cwd_pkg::CFG_OSC_HI:cwd_pkg::CFG_OSC_LO]));
      hold_reset              <= (state_r != ST_RUN) || powerup_timer_busy || powerup_timer_start;
    end
  end

  assign status_word = {9'h000, powerup_timer_busy, hold_reset, watchdog_enable,
                        brownout_reset_enable, external_reset_req,
                        program_read_protect, data_read_protect};

  always_comb
  begin
    unique case (reg_req.addr)
      cwd_pkg::REG_CONFIG:  rdata_nxt = {cwd_pkg::CFG_TOP_ONES, cfg_r};
      cwd_pkg::REG_CALIB:   rdata_nxt = calib_word;
      cwd_pkg::REG_CONTROL: rdata_nxt = {14'h0000, sw_wdt_r, sw_bor_r};
      cwd_pkg::REG_STATUS:  rdata_nxt = status_word;
      default:              rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (ce)
      reg_rdata <= reg_req.rd ? rdata_nxt : 16'h0000;
  end

endmodule : cwd_config_decoder

`default_nettype wire

/* File: dv/cwd_config_decoder_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module cwd_config_decoder_checker #(
  parameter int unsigned POWERUP_TIMER_CYCLES = 20
) (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       ce,
  input wire cwd_pkg::cwd_reg_req_t      reg_req,
  input wire logic [cwd_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       external_reset_req,
  input wire logic                       reset_pin_is_input,
  input wire logic                       data_read_protect,
  input wire logic                       program_read_protect,
  input wire logic                       data_erase,
  input wire logic                       program_erase,
  input wire cwd_pkg::cwd_osc_t          osc_cfg,
  input wire logic                       internal_osc_run,
  input wire logic                       hold_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cfg_rd;
    reg_req.rd && ce && reg_req.addr == cwd_pkg::REG_CONFIG;
  endsequence

  sequence s_int_or_rc;
    osc_cfg.source inside {cwd_pkg::CWD_SRC_RC, cwd_pkg::CWD_SRC_INTERNAL};
  endsequence

  a_rdata_idle: assert property (!(reg_req.rd && ce) |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_top_ones: assert property (s_cfg_rd |=> reg_rdata[15:12] == 4'hF)
    else $error("config top bits not read as ones");
  a_pin_input: assert property (reset_pin_is_input |-> !external_reset_req)
    else $error("external reset asserted while pin is an input");
  a_data_unprot: assert property (data_erase |=> !data_read_protect)
    else $error("data erase without data protection lifted");
  a_prog_unprot: assert property (program_erase |=> !program_read_protect)
    else $error("program erase without program protection lifted");
  a_int_clkin: assert property (
    osc_cfg.source == cwd_pkg::CWD_SRC_INTERNAL |-> osc_cfg.clkin_is_io)
    else $error("internal clock mode keeps clock-in pin");
  a_clkout_excl: assert property (osc_cfg.clkout_drive |-> !osc_cfg.osc2_is_io)
    else $error("clock out and general pin at once");
  a_osc_stop: assert property (
    external_reset_req ##0 s_int_or_rc |-> !internal_osc_run)
    else $error("internal oscillator runs during external reset");
  a_hold_start: assert property ($fell(rst) |-> hold_reset [*2])
    else $error("consumers released before the word was loaded");
endmodule : cwd_config_decoder_checker

bind cwd_config_decoder cwd_config_decoder_checker #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES)) chk_i (
  .clk(clk), .rst(rst), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .external_reset_req(external_reset_req), .reset_pin_is_input(reset_pin_is_input),
  .data_read_protect(data_read_protect), .program_read_protect(program_read_protect),
  .data_erase(data_erase), .program_erase(program_erase), .osc_cfg(osc_cfg),
  .internal_osc_run(internal_osc_run), .hold_reset(hold_reset)
);

`default_nettype wire

/* File: dv/cwd_prog_model.sv */
`timescale 1ns/100ps
`default_nettype none

module cwd_prog_model #(
  parameter logic [11:0] CFG_INIT   = 12'hFE7,
  parameter logic [15:0] CALIB_INIT = 16'h5A3C
) (
  input  wire logic        prog_req,
  output var  logic        prog_mode,
  output var  logic [11:0] nv_config,
  output var  logic [15:0] nv_calib
);
  // stored words as left by the programmer
  always_comb
  begin
    prog_mode = prog_req;
    nv_config = CFG_INIT;
    nv_calib  = CALIB_INIT;
  end
endmodule : cwd_prog_model

`default_nettype wire

/* File: dv/cwd_config_decoder_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module cwd_config_decoder_tb_top;
  localparam int PW = 20;
  logic clk, rst, ce, prog_req, prog_mode, ext_n, sleep, bo, osc_run, hold;
  logic cm, sw, bre, dp, pp, xr, pin_in, wdt, de, pe;
  logic [11:0] nv_config;
  logic [15:0] nv_calib, rdata, calib;
  cwd_pkg::cwd_reg_req_t req;
  cwd_pkg::cwd_osc_t osc;
  int n_fail = 0;
  int num_checks = 0;

  cwd_prog_model cwd_prog_model_i (.prog_req(prog_req), .prog_mode(prog_mode),
    .nv_config(nv_config), .nv_calib(nv_calib));
  cwd_config_decoder #(.POWERUP_TIMER_CYCLES(PW)) cwd_config_decoder_i (
    .clk(clk), .rst(rst), .ce(ce), .reg_req(req), .reg_rdata(rdata),
    .prog_mode(prog_mode), .nv_config(nv_config), .nv_calib(nv_calib),
    .external_reset_n(ext_n), .sleep_active(sleep), .brownout_event(bo),
    .clock_monitor_enable(cm), .clock_switchover_enable(sw),
    .brownout_reset_enable(bre), .data_read_protect(dp), .program_read_protect(pp),
    .external_reset_req(xr), .reset_pin_is_input(pin_in), .watchdog_enable(wdt),
    .osc_cfg(osc), .internal_osc_run(osc_run), .hold_reset(hold),
    .data_erase(de), .program_erase(pe), .calib_word(calib));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk1(string nm, logic e, logic g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk1

  task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk16

  task automatic chkosc(cwd_pkg::cwd_osc_t e);
    num_checks++;
    if (osc !== e)
    begin
      n_fail++;
      $display("BAD osc_cfg exp %0h got %0h", e, osc);
    end
  endtask : chkosc

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [3:0] a, logic [15:0] e, string nm);
    @(posedge clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    chk16(nm, e, rdata);
  endtask : rd

  task automatic cfg(logic [11:0] c);
    wr(cwd_pkg::REG_CONFIG, {4'hF, c});
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : cfg

  function automatic cwd_pkg::cwd_osc_t osc_exp(logic [2:0] k);
    case (k)
      3'h7: osc_exp = '{cwd_pkg::CWD_SRC_RC, 1'b1, 1'b0, 1'b0};
      3'h6: osc_exp = '{cwd_pkg::CWD_SRC_RC, 1'b0, 1'b0, 1'b1};
      3'h5: osc_exp = '{cwd_pkg::CWD_SRC_INTERNAL, 1'b1, 1'b1, 1'b0};
      3'h4: osc_exp = '{cwd_pkg::CWD_SRC_INTERNAL, 1'b0, 1'b1, 1'b1};
      3'h3: osc_exp = '{cwd_pkg::CWD_SRC_EXT_CLOCK, 1'b0, 1'b0, 1'b1};
      3'h2: osc_exp = '{cwd_pkg::CWD_SRC_HS, 1'b0, 1'b0, 1'b0};
      3'h1: osc_exp = '{cwd_pkg::CWD_SRC_XT, 1'b0, 1'b0, 1'b0};
      default: osc_exp = '{cwd_pkg::CWD_SRC_LP, 1'b0, 1'b0, 1'b0};
    endcase
  endfunction : osc_exp

  task automatic t_decode;
    logic [11:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = 12'h9E8 ^ (12'h2D8 * i[11:0]);
      c[2:0] = i[2:0];
      cfg(c);
      chk1("clk_mon", c[11], cm);
      chk1("switchover", c[10], sw);
      chk1("bor_en", c[9], bre);
      chk1("data_prot", !c[7], dp);
      chk1("prog_prot", !c[6], pp);
      chk1("pin_input", !c[5], pin_in);
      chk1("wdt", c[3], wdt);
      chkosc(osc_exp(c[2:0]));
      rd(cwd_pkg::REG_CONFIG, {4'hF, c}, "cfg_read");
    end
  endtask : t_decode

  task automatic t_soft;
    cfg(12'h1F0);
    wr(cwd_pkg::REG_CONTROL, 16'h0001);
    cfg(12'h1F0);
    chk1("bor_sw_on", 1'b1, bre);
    cfg(12'h2F0);
    @(posedge clk);
    sleep <= 1'b1;
    cfg(12'h2F0);
    chk1("bor_sleep", 1'b0, bre);
    @(posedge clk);
    sleep <= 1'b0;
    cfg(12'h2F0);
    chk1("bor_wake", 1'b1, bre);
    wr(cwd_pkg::REG_CONTROL, 16'h0002);
    rd(cwd_pkg::REG_CONTROL, 16'h0002, "ctl_read");
    cfg(12'h1F0);
    chk1("bor_sw_off", 1'b0, bre);
    chk1("wdt_sw", 1'b1, wdt);
    wr(cwd_pkg::REG_CONTROL, 16'h0000);
  endtask : t_soft

  task automatic t_pin;
    @(posedge clk);
    ext_n <= 1'b0;
    cfg(12'hFF4);
    chk1("ext_req", 1'b1, xr);
    chk1("osc_stop", 1'b0, osc_run);
    cfg(12'hFD4);
    chk1("ext_req_off", 1'b0, xr);
    chk1("pin_in", 1'b1, pin_in);
    @(posedge clk);
    ext_n <= 1'b1;
  endtask : t_pin

  task automatic t_erase;
    cfg(12'hF37);
    chk1("data_prot_on", 1'b1, dp);
    wr(cwd_pkg::REG_CONFIG, 16'hFFB7);
    @(negedge clk);
    chk1("data_erase", 1'b1, de);
    chk1("prog_keep", 1'b0, pe);
    cfg(12'hF37);
    wr(cwd_pkg::REG_ERASE, 16'h0001);
    @(negedge clk);
    chk1("bulk_data", 1'b1, de);
    chk1("bulk_prog", 1'b1, pe);
    rd(cwd_pkg::REG_CONFIG, 16'hFFFF, "erased_cfg");
    rd(cwd_pkg::REG_CALIB, 16'h5A3C, "calib_read");
    chk16("calib", 16'h5A3C, calib);
    @(posedge clk);
    prog_req <= 1'b0;
    wr(cwd_pkg::REG_CONFIG, 16'hF000);
    wr(cwd_pkg::REG_CALIB, 16'h0000);
    rd(cwd_pkg::REG_CONFIG, 16'hFFFF, "locked_cfg");
    rd(4'hF, 16'h0000, "unmapped");
    chk16("calib_locked", 16'h5A3C, calib);
    @(posedge clk);
    prog_req <= 1'b1;
  endtask : t_erase

  task automatic t_timer(logic [11:0] c, logic e);
    int n;
    cfg(c);
    @(posedge clk);
    bo <= 1'b1;
    @(posedge clk);
    bo <= 1'b0;
    repeat (3) @(negedge clk);
    chk1("bo_hold", e, hold);
    n = 0;
    while (hold === 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk1("bo_release", 1'b0, hold);
  endtask : t_timer

  initial
  begin
    int n;
    rst = 1'b1;
    ce = 1'b1;
    prog_req = 1'b1;
    ext_n = 1'b1;
    sleep = 1'b0;
    bo = 1'b0;
    req = '{4'h0, 16'h0000, 1'b0, 1'b0};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    @(negedge clk);
    while (hold === 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk1("powerup_timer_len", 1'b1, n >= PW && n <= PW + 6);
    t_decode();
    t_soft();
    t_pin();
    t_erase();
    t_timer(12'hFE7, 1'b1);
    t_timer(12'hFF7, 1'b0);
    summarize();
  end

  initial
  begin
    #40000;
    n_fail++;
    summarize();
  end
endmodule : cwd_config_decoder_tb_top

`default_nettype wire
